// File: include/shse_pkg.sv
// constants and types shared by the skip, halt and subtract logic
package shse_pkg;

  // widths of the core datapath
  localparam int INSTR_W = 16;
  localparam int PC_W = 11;
  localparam int DATA_W = 4;
  localparam int ADDR_W = 7;
  localparam int WSEL_W = 4;
  localparam int RAM_DEPTH = 128;

  // opcode prefix widths and field positions
  localparam int PFX9_W = 9;
  localparam int PFX8_W = 8;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 0;
  localparam int IMM_MSB = 7;
  localparam int IMM_LSB = 4;
  localparam int WSEL_MSB = 3;
  localparam int WSEL_LSB = 0;
  localparam int BIT3_POS = 3;
  localparam int BIT2_POS = 2;

  // opcode prefixes
  localparam logic [PFX9_W-1:0] OP_TEST_BIT3 = 9'h115;
  localparam logic [PFX9_W-1:0] OP_TEST_BIT2 = 9'h114;
  localparam logic [PFX9_W-1:0] OP_MEM_MINUS_ACC = 9'h034;
  localparam logic [PFX9_W-1:0] OP_MEM_MINUS_ACC_WB = 9'h036;
  localparam logic [PFX8_W-1:0] OP_WR_MINUS_IMM = 8'h1E;
  // full word of the oscillator-halt instruction
  localparam logic [INSTR_W-1:0] OP_OSC_HALT = 16'h0001;

  // program counter steps and reset values
  localparam logic [PC_W-1:0] PC_STEP_NEXT = 11'h001;
  localparam logic [PC_W-1:0] PC_STEP_SKIP = 11'h002;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [DATA_W-1:0] NIBBLE_RESET = 4'h0;
  localparam logic [ADDR_W-WSEL_W-1:0] WR_PAGE = 3'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic WAKE_IDLE = 1'b1;

  // execution mode of the core
  typedef enum logic {MODE_RUN, MODE_STOP} shse_mode_e;

  // decoded instruction kind
  typedef enum logic [2:0]
  {
    OPK_OTHER,
    OPK_TEST_BIT2,
    OPK_TEST_BIT3,
    OPK_OSC_HALT,
    OPK_MEM_MINUS_ACC,
    OPK_MEM_MINUS_ACC_WB,
    OPK_WR_MINUS_IMM
  } shse_opk_e;

  // result of the nibble subtractor
  typedef struct packed
  {
    logic [DATA_W-1:0] diff;
    logic carry;
    logic zero;
  } shse_alu_s;

endpackage

// File: verilog/shse_sub.sv
// nibble subtractor with borrow and zero flags
module shse_sub
(
  input wire logic [shse_pkg::DATA_W-1:0] minuend,
  input wire logic [shse_pkg::DATA_W-1:0] subtrahend,
  output shse_pkg::shse_alu_s result
);

  logic [shse_pkg::DATA_W:0] wide;

  // one extra bit catches the borrow out of the top bit
  always_comb
  begin
    wide = {1'b0, minuend} - {1'b0, subtrahend};
    result.diff = wide[shse_pkg::DATA_W-1:0];
    result.carry = wide[shse_pkg::DATA_W];
    result.zero = (wide[shse_pkg::DATA_W-1:0] == shse_pkg::NIBBLE_RESET);
  end

endmodule

// File: verilog/shse_core.sv
// decode and execute of skip, oscillator halt and subtract instructions
//
// Function
// - Bit-3 test-and-skip is recognised by its 9-bit prefix and its low 7 bits address one memory nibble.
// - When bit 3 of that nibble is one the program counter steps by two, skipping the next instruction.
// - When bit 3 is zero the program counter steps by one, and the instruction takes one cycle.
// - The halt instruction takes one cycle and puts the core in stop mode where nothing executes.
// - In stop mode a falling edge on the wake port wakes the core, which resumes at the following instruction.
// - Memory-minus-accumulator loads only the accumulator with the difference and updates both flags.
// - Working-register-minus-immediate loads only the accumulator with the difference and updates both flags.
// - In that form the immediate sits after the 8-bit prefix and the low field picks one of sixteen working registers.
// - The write-back form stores the difference in both the accumulator and the addressed memory nibble.
module shse_core
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [shse_pkg::INSTR_W-1:0] instr,
  input wire logic instr_valid,
  input wire logic wake_input_port,
  input wire logic load_en,
  input wire logic [shse_pkg::ADDR_W-1:0] load_addr,
  input wire logic [shse_pkg::DATA_W-1:0] load_data,
  input wire logic [shse_pkg::ADDR_W-1:0] peek_addr,
  output logic [shse_pkg::PC_W-1:0] pc_ff,
  output logic [shse_pkg::DATA_W-1:0] result_nibble_register_ff,
  output logic carry_flag_ff,
  output logic zero_flag_ff,
  output logic osc_stopped_ff,
  output logic [shse_pkg::DATA_W-1:0] peek_data_ff
);

  // data memory, working registers in the lowest sixteen nibbles
  logic [shse_pkg::DATA_W-1:0] ram [shse_pkg::RAM_DEPTH];

  shse_pkg::shse_mode_e mode_ff;
  shse_pkg::shse_mode_e nxt_mode;
  shse_pkg::shse_opk_e opk;
  shse_pkg::shse_alu_s alu;

  logic wake_meta_ff;
  logic wake_sync_ff;
  logic wake_prev_ff;
  logic wake_fall;
  logic exec;
  logic is_sub;
  logic skip_taken;
  logic [shse_pkg::ADDR_W-1:0] mem_addr;
  logic [shse_pkg::DATA_W-1:0] operand;
  logic [shse_pkg::DATA_W-1:0] imm;
  logic [shse_pkg::DATA_W-1:0] subtrahend;
  logic [shse_pkg::PC_W-1:0] nxt_pc;

  // compare the top nine bits of a word with a prefix
  function automatic logic pfx9_hit
  (
    input logic [shse_pkg::INSTR_W-1:0] word,
    input logic [shse_pkg::PFX9_W-1:0] pfx
  );
    return word[shse_pkg::INSTR_W-1 -: shse_pkg::PFX9_W] == pfx;
  endfunction

  // classify the instruction word; the halt word is matched in full
  always_comb
  begin
    opk = shse_pkg::OPK_OTHER;
    if (instr == shse_pkg::OP_OSC_HALT)
    begin
      opk = shse_pkg::OPK_OSC_HALT;
    end
    else if (pfx9_hit(instr, shse_pkg::OP_TEST_BIT3))
    begin
      opk = shse_pkg::OPK_TEST_BIT3;
    end
    else if (pfx9_hit(instr, shse_pkg::OP_TEST_BIT2))
    begin
      opk = shse_pkg::OPK_TEST_BIT2;
    end
    else if (pfx9_hit(instr, shse_pkg::OP_MEM_MINUS_ACC))
    begin
      opk = shse_pkg::OPK_MEM_MINUS_ACC;
    end
    else if (pfx9_hit(instr, shse_pkg::OP_MEM_MINUS_ACC_WB))
    begin
      opk = shse_pkg::OPK_MEM_MINUS_ACC_WB;
    end
    else if (instr[shse_pkg::INSTR_W-1 -: shse_pkg::PFX8_W] ==
             shse_pkg::OP_WR_MINUS_IMM)
    begin
      opk = shse_pkg::OPK_WR_MINUS_IMM;
    end
  end

  // operand address: memory field, or working register page
  always_comb
  begin
    imm = instr[shse_pkg::IMM_MSB:shse_pkg::IMM_LSB];
    if (opk == shse_pkg::OPK_WR_MINUS_IMM)
    begin
      mem_addr = {shse_pkg::WR_PAGE,
                  instr[shse_pkg::WSEL_MSB:shse_pkg::WSEL_LSB]};
    end
    else
    begin
      mem_addr = instr[shse_pkg::ADDR_MSB:shse_pkg::ADDR_LSB];
    end
    operand = ram[mem_addr];
  end

  // subtrahend is the immediate or the accumulator
  always_comb
  begin
    if (opk == shse_pkg::OPK_WR_MINUS_IMM)
    begin
      subtrahend = imm;
    end
    else
    begin
      subtrahend = result_nibble_register_ff;
    end
  end

  shse_sub u_sub
  (
    .minuend(operand),
    .subtrahend(subtrahend),
    .result(alu)
  );

  // nothing executes while stopped; one word per cycle otherwise
  assign exec = instr_valid && (mode_ff == shse_pkg::MODE_RUN);
  assign is_sub = (opk == shse_pkg::OPK_MEM_MINUS_ACC) ||
                  (opk == shse_pkg::OPK_MEM_MINUS_ACC_WB) ||
                  (opk == shse_pkg::OPK_WR_MINUS_IMM);

  // skip decision for the two bit tests
  always_comb
  begin
    case (opk)
      shse_pkg::OPK_TEST_BIT3:
        skip_taken = operand[shse_pkg::BIT3_POS];
      shse_pkg::OPK_TEST_BIT2:
        skip_taken = operand[shse_pkg::BIT2_POS];
      default:
        skip_taken = 1'b0;
    endcase
  end

  // next program counter; a skip jumps over one word
  always_comb
  begin
    if (skip_taken)
    begin
      nxt_pc = pc_ff + shse_pkg::PC_STEP_SKIP;
    end
    else
    begin
      nxt_pc = pc_ff + shse_pkg::PC_STEP_NEXT;
    end
  end

  // program counter; halt still steps so the wake resumes after it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pc_ff <= shse_pkg::PC_RESET;
    end
    else if (exec)
    begin
      pc_ff <= nxt_pc;
    end
  end

  // accumulator takes every subtract result
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      result_nibble_register_ff <= shse_pkg::NIBBLE_RESET;
    end
    else if (exec && is_sub)
    begin
      result_nibble_register_ff <= alu.diff;
    end
  end

  // carry and zero flags, touched only by the subtracts
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      carry_flag_ff <= shse_pkg::FLAG_RESET;
      zero_flag_ff <= shse_pkg::FLAG_RESET;
    end
    else if (exec && is_sub)
    begin
      carry_flag_ff <= alu.carry;
      zero_flag_ff <= alu.zero;
    end
  end

  // data memory; the write-back form wins over the loader
  always_ff @(posedge clock)
  begin
    if (exec && (opk == shse_pkg::OPK_MEM_MINUS_ACC_WB))
    begin
      ram[mem_addr] <= alu.diff;
    end
    else if (load_en)
    begin
      ram[load_addr] <= load_data;
    end
  end

  // registered view of one memory nibble
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      peek_data_ff <= shse_pkg::NIBBLE_RESET;
    end
    else
    begin
      peek_data_ff <= ram[peek_addr];
    end
  end

  // wake pin is asynchronous: two flops, then an edge stage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wake_meta_ff <= shse_pkg::WAKE_IDLE;
      wake_sync_ff <= shse_pkg::WAKE_IDLE;
      wake_prev_ff <= shse_pkg::WAKE_IDLE;
    end
    else
    begin
      wake_meta_ff <= wake_input_port;
      wake_sync_ff <= wake_meta_ff;
      wake_prev_ff <= wake_sync_ff;
    end
  end

  assign wake_fall = wake_prev_ff && !wake_sync_ff;

  // run/stop mode; edges seen while running are dropped
  always_comb
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      shse_pkg::MODE_RUN:
        if (exec && (opk == shse_pkg::OPK_OSC_HALT))
        begin
          nxt_mode = shse_pkg::MODE_STOP;
        end
      shse_pkg::MODE_STOP:
        if (wake_fall)
        begin
          nxt_mode = shse_pkg::MODE_RUN;
        end
      default:
        nxt_mode = shse_pkg::MODE_RUN;
    endcase
  end

  // the clock itself keeps running; stop gates execution instead
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= shse_pkg::MODE_RUN;
      osc_stopped_ff <= shse_pkg::FLAG_RESET;
    end
    else
    begin
      mode_ff <= nxt_mode;
      osc_stopped_ff <= (nxt_mode == shse_pkg::MODE_STOP);
    end
  end

endmodule

// File: verification/shse_core_checker.sv
// assertions on the ports of the skip, halt and subtract core
module shse_core_checker
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic wake_input_port,
  input wire logic load_en,
  input wire logic [6:0] load_addr,
  input wire logic [3:0] load_data,
  input wire logic [6:0] peek_addr,
  input wire logic [10:0] pc_ff,
  input wire logic [3:0] result_nibble_register_ff,
  input wire logic carry_flag_ff,
  input wire logic zero_flag_ff,
  input wire logic osc_stopped_ff,
  input wire logic [3:0] peek_data_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  // decoded kind of the word taken at this edge
  wire logic go = instr_valid && !osc_stopped_ff;
  wire logic [3:0] acc = result_nibble_register_ff;
  wire logic [3:0] imm = instr[7:4];
  wire logic sub_r = go && (instr[15:7] == shse_pkg::OP_MEM_MINUS_ACC
    || instr[15:7] == shse_pkg::OP_MEM_MINUS_ACC_WB);
  wire logic sub_i = go && instr[15:8] == shse_pkg::OP_WR_MINUS_IMM;
  wire logic skip = go && (instr[15:7] == shse_pkg::OP_TEST_BIT3
    || instr[15:7] == shse_pkg::OP_TEST_BIT2);
  a_halt_stops: assert property (
    go && instr == shse_pkg::OP_OSC_HALT
    |=> osc_stopped_ff && pc_ff == $past(pc_ff) + 11'h001)
    else $error("halt did not stop the core");
  a_stop_frozen: assert property (
    osc_stopped_ff |=> $stable(pc_ff) && $stable(acc))
    else $error("state moved while stopped");
  a_wake_bound: assert property (
    (osc_stopped_ff && wake_input_port) ##1 (!wake_input_port) [*3]
    |-> ##[0:2] !osc_stopped_ff)
    else $error("no wake after falling edge");
  a_no_early_wake: assert property (
    (osc_stopped_ff && wake_input_port) [*3] |=> osc_stopped_ff)
    else $error("woke without falling edge");
  a_mem_borrow: assert property (
    sub_r |=> carry_flag_ff == ({1'h0, acc} + {1'h0, $past(acc)} > 5'h0F))
    else $error("memory subtract carry wrong");
  a_imm_borrow: assert property (
    sub_i |=> carry_flag_ff == ({1'h0, acc} + {1'h0, $past(imm)} > 5'h0F))
    else $error("immediate subtract carry wrong");
  a_sub_zero: assert property (
    sub_r || sub_i |=> zero_flag_ff == (acc == 4'h0)
      && pc_ff == $past(pc_ff) + 11'h001)
    else $error("subtract zero or step wrong");
  a_skip_step: assert property (
    skip |=> $stable(acc) && $stable(carry_flag_ff)
      && (pc_ff == $past(pc_ff) + 11'h001 || pc_ff == $past(pc_ff) + 11'h002))
    else $error("skip step or flags wrong");
endmodule

bind shse_core shse_core_checker chk
(
  .clock(clock), .rst(rst), .instr(instr), .instr_valid(instr_valid),
  .wake_input_port(wake_input_port), .load_en(load_en),
  .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
  .pc_ff(pc_ff), .result_nibble_register_ff(result_nibble_register_ff),
  .carry_flag_ff(carry_flag_ff), .zero_flag_ff(zero_flag_ff),
  .osc_stopped_ff(osc_stopped_ff), .peek_data_ff(peek_data_ff)
);

// File: verification/shse_core_tb.sv
// self-checking bench for the skip, halt and subtract core
module shse_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic [10:0] pc;
    logic [3:0] acc;
    logic c;
    logic z;
    logic st;
    logic [3:0] pk;
    int due;
  } shse_note_s;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic instr_valid = 1'h0;
  logic wake_input_port = 1'h1;
  logic load_en = 1'h0;
  logic [15:0] instr = 16'h0000;
  logic [6:0] load_addr = 7'h00;
  logic [6:0] peek_addr = 7'h00;
  logic [3:0] load_data = 4'h0;
  logic [10:0] pc_ff;
  logic [3:0] acc_seen, pk_seen;
  logic c_seen, z_seen, st_seen;
  // reference state, kept apart from the design
  logic [3:0] ram [128];
  logic [10:0] m_pc = 11'h000;
  logic [3:0] m_acc = 4'h0;
  logic m_c = 1'h0, m_z = 1'h0, m_st = 1'h0, wk_prev = 1'h1;
  int wcnt = 0, cyc = 0, bad_count = 0, comparisons = 0;
  integer seed = 32'h12B9BF02;
  shse_note_s q[$];
  // last kind is a word no decoder claims: it may only step the pc
  logic [15:0] kinds [6] = '{{shse_pkg::OP_TEST_BIT3, 7'h00},
    {shse_pkg::OP_TEST_BIT2, 7'h00}, {shse_pkg::OP_MEM_MINUS_ACC, 7'h00},
    {shse_pkg::OP_MEM_MINUS_ACC_WB, 7'h00},
    {shse_pkg::OP_WR_MINUS_IMM, 8'h00}, 16'hC000};

  shse_core dut
  (
    .clock(clock), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .wake_input_port(wake_input_port), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
    .pc_ff(pc_ff), .result_nibble_register_ff(acc_seen),
    .carry_flag_ff(c_seen), .zero_flag_ff(z_seen),
    .osc_stopped_ff(st_seen), .peek_data_ff(pk_seen)
  );

  // 250 MHz core clock
  initial forever #2 clock = ~clock;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [10:0] e,
    input logic [10:0] s);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // one clock of stimulus; the note says what shows after the next edge
  task automatic step(input logic v, input logic [15:0] w, input logic le,
    input logic [6:0] la, input logic [3:0] ld, input logic wk);
    logic [6:0] pa;
    logic [3:0] x, y, pk;
    logic st0, wb, imm;
    pa = 7'($random(seed));
    pk = ram[pa];
    st0 = m_st;
    wb = w[15:7] == shse_pkg::OP_MEM_MINUS_ACC_WB;
    imm = w[15:8] == shse_pkg::OP_WR_MINUS_IMM;
    @(posedge clock);
    instr_valid <= v;
    instr <= w;
    load_en <= le;
    load_addr <= la;
    load_data <= ld;
    peek_addr <= pa;
    wake_input_port <= wk;
    if (v && !st0)
    begin
      m_pc = m_pc + 11'h001;
      if (w == shse_pkg::OP_OSC_HALT)
        m_st = 1'h1;
      else if (w[15:7] == shse_pkg::OP_TEST_BIT3)
        m_pc = m_pc + {10'h000, ram[w[6:0]][3]};
      else if (w[15:7] == shse_pkg::OP_TEST_BIT2)
        m_pc = m_pc + {10'h000, ram[w[6:0]][2]};
      else if (wb || imm || w[15:7] == shse_pkg::OP_MEM_MINUS_ACC)
      begin
        x = imm ? ram[{3'h0, w[3:0]}] : ram[w[6:0]];
        y = imm ? w[7:4] : m_acc;
        m_acc = x - y;
        m_c = x < y;
        m_z = m_acc == 4'h0;
      end
    end
    // an executed write-back drops the load of the same edge entirely
    if (le && !(wb && v && !st0))
      ram[la] = ld;
    if (wb && v && !st0)
      ram[w[6:0]] = m_acc;
    // wake lands two notes after the low is first driven
    if (wcnt == 1)
      m_st = 1'h0;
    if (wcnt > 0)
      wcnt--;
    if (st0 && wk_prev && !wk)
      wcnt = 2;
    wk_prev = wk;
    if (v || !le)
      q.push_back({m_pc, m_acc, m_c, m_z, m_st, pk, cyc + 1});
  endtask

  // compare each settled result with the oldest note
  always @(negedge clock)
  begin
    if (q.size() != 0 && q[0].due == cyc)
    begin
      cmp("pc", q[0].pc, pc_ff);
      cmp("acc", q[0].acc, acc_seen);
      cmp("carry", q[0].c, c_seen);
      cmp("zero", q[0].z, z_seen);
      cmp("stopped", q[0].st, st_seen);
      cmp("peek", q[0].pk, pk_seen);
      void'(q.pop_front());
    end
    cyc++;
  end

  // watchdog far beyond the expected run of some 600 cycles
  initial
  begin
    #20000;
    bad_count++;
    give_verdict();
  end

  // preload, random traffic with loads alongside, then two halt and wakes
  initial
  begin
    int i;
    logic [2:0] k;
    logic [15:0] w;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    for (i = 0; i < 128; i++)
      step(1'h0, 16'h0000, 1'h1, 7'(i), 4'($random(seed)), 1'h1);
    repeat (400)
    begin
      k = 3'($unsigned($random(seed)) % 6);
      w = kinds[k] | (16'($random(seed)) & (k == 3'h4 ? 16'h00FF : 16'h007F));
      step(3'($random(seed)) != 3'h0, w, 1'($random(seed)),
        7'($random(seed)), 4'($random(seed)), 1'h1);
    end
    repeat (2)
    begin
      step(1'h1, shse_pkg::OP_OSC_HALT, 1'h0, 7'h00, 4'h0, 1'h1);
      for (i = 0; i < 9; i++)
        step(1'h1, 16'h1E10 | 16'(i), 1'h0, 7'h00, 4'h0,
          i < 3 || i > 5);
    end
    repeat (3) step(1'h0, 16'h0000, 1'h0, 7'h00, 4'h0, 1'h1);
    repeat (2) @(posedge clock);
    give_verdict();
  end
endmodule
